// file: cer_map.svh
// Constants and overview for cache error recovery control
`ifndef CER_MAP_SVH
`define CER_MAP_SVH
// Overview of operation
// - Nonexistent read sets timeout, noack, hard interrupt
// - Bridge returns read error; fill status locks, soft interrupt
// - I/O references wait until instruction executes
// - Writes wait for data; only memory reads speculate
// - Only conditional mispredictions cause wrong-path fetches
// - Wrong-path access violation discarded on mispredict
// - Primary cache stays coherent in transition mode
// - Return-from-exception flushes instruction cache
// - Translation parity error invalidates whole buffer
// - Load process context clears process entries
`define CER_BER_TIMEOUT_BIT 0
`define CER_BER_NOACK_BIT 1
`define CER_FES_RDE_BIT 0
`define CER_FES_LOCK_BIT 1
`define CER_BC_MODE_W 2
`define CER_BC_OFF 2'h0
`define CER_BC_ON 2'h1
`define CER_BC_ETM 2'h2
`endif

// file: cer_pkg.sv
// Types for cache error recovery control
package cer_pkg;
   typedef logic [1:0] cer_bc_mode_t;
   typedef enum logic [1:0] {CER_REQ_MEM_READ, CER_REQ_MEM_WRITE, CER_REQ_IO} cer_req_kind_t;
endpackage

// file: cer_req_if.sv
// Interface carrying a speculative request between gate and top
`timescale 1ns/1ps
interface cer_req_if;
   import cer_pkg::*;
   logic valid;
   cer_req_kind_t kind;
   logic speculative;
   logic executing;
   logic data_ready;
   logic issue;
   modport src (output valid, output kind, output speculative, output executing, output data_ready, input issue);
   modport gate (input valid, input kind, input speculative, input executing, input data_ready, output issue);
endinterface

// file: cer_issue_gate.sv
// Issue gating of speculative references
`timescale 1ns/1ps
module cer_issue_gate (
   cer_req_if.gate req
);
   import cer_pkg::*;
   always_comb begin
      req.issue = 1'b0;
      if (req.valid) begin
         case (req.kind)
            CER_REQ_MEM_READ: req.issue = 1'b1;
            CER_REQ_MEM_WRITE: req.issue = req.data_ready && !req.speculative;
            CER_REQ_IO: req.issue = req.executing && !req.speculative;
            default: req.issue = 1'b0;
         endcase
      end
   end
endmodule

// file: cer_tb_flush.sv
// Translation buffer valid bits with invalidate operations
`timescale 1ns/1ps
module cer_tb_flush #(
   parameter int ENTRIES = 8
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic fill,
   input wire logic [$clog2(ENTRIES)-1:0] fill_index,
   input wire logic fill_process,
   input wire logic inval_all,
   input wire logic inval_single,
   input wire logic [$clog2(ENTRIES)-1:0] single_index,
   input wire logic clear_process,
   output logic [ENTRIES-1:0] valid
);
   logic [ENTRIES-1:0] proc_space;
   logic [ENTRIES-1:0] next_valid;
   logic [ENTRIES-1:0] next_proc_space;
   always_comb begin
      next_valid = valid;
      next_proc_space = proc_space;
      for (int i = 0; i < ENTRIES; i++) begin
         if (fill && fill_index == i[$clog2(ENTRIES)-1:0]) begin
            next_valid[i] = 1'b1;
            next_proc_space[i] = fill_process;
         end
         if (inval_single && single_index == i[$clog2(ENTRIES)-1:0]) begin
            next_valid[i] = 1'b0;
         end
         if (clear_process && proc_space[i]) begin
            next_valid[i] = 1'b0;
         end
      end
      if (inval_all) begin
         next_valid = '0;
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         valid <= '0;
         proc_space <= '0;
      end else begin
         valid <= next_valid;
         proc_space <= next_proc_space;
      end
   end
   chk_translation_invalidate_all_clears: assert property (@(posedge clock) disable iff (!rst_b)
      inval_all |=> valid == '0) else $error("invalidate-all left valid entries");
   chk_load_process_context_instr_proc: assert property (@(posedge clock) disable iff (!rst_b)
      (clear_process && !fill) |=> (valid & $past(proc_space)) == '0) else $error("process entry survived");
endmodule

// file: cer_top.sv
// Cache error recovery control top
`timescale 1ns/1ps
`include "cer_map.svh"
module cer_top #(
   parameter int TB_ENTRIES = 8
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic nxm_read,
   input wire logic ber_clear,
   input wire logic fes_clear,
   output logic [1:0] bus_error_register,
   output logic [1:0] fill_error_status_register,
   output logic hard_error_irq,
   output logic soft_error_irq,
   output logic read_data_error,
   input wire logic req_valid,
   input wire cer_pkg::cer_req_kind_t req_kind,
   input wire logic req_speculative,
   input wire logic req_executing,
   input wire logic req_data_ready,
   output logic req_issue,
   input wire logic prefetch_wrong_path,
   input wire logic branch_conditional,
   input wire logic mispredict,
   input wire logic prefetch_acv,
   output logic acv_pending,
   output logic acv_fault,
   output logic wrong_path_drop,
   input wire logic icache_enable,
   input wire logic pcache_enable,
   input wire logic [1:0] bcache_mode,
   output logic icache_on,
   output logic pcache_on,
   output logic pcache_coherent,
   input wire logic rei_exec,
   output logic icache_flush,
   input wire logic tb_fill,
   input wire logic [$clog2(TB_ENTRIES)-1:0] tb_fill_index,
   input wire logic tb_fill_process,
   input wire logic tb_parity_error,
   input wire logic tb_inval_all,
   input wire logic tb_inval_single,
   input wire logic [$clog2(TB_ENTRIES)-1:0] tb_single_index,
   input wire logic load_process_context_instr_exec,
   output logic [TB_ENTRIES-1:0] tb_valid
);
   import cer_pkg::*;

   // ****************************************
   // Error reporting
   // ****************************************
   logic [1:0] next_ber;
   logic [1:0] next_fes;
   logic next_rde;
   always_comb begin
      next_ber = bus_error_register;
      next_fes = fill_error_status_register;
      if (ber_clear) begin
         next_ber = 2'h0;
      end
      if (fes_clear) begin
         next_fes = 2'h0;
      end
      if (nxm_read) begin
         next_ber[`CER_BER_TIMEOUT_BIT] = 1'b1;
         next_ber[`CER_BER_NOACK_BIT] = 1'b1;
      end
      next_rde = nxm_read;
      if (read_data_error) begin
         next_fes[`CER_FES_RDE_BIT] = 1'b1;
         next_fes[`CER_FES_LOCK_BIT] = 1'b1;
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         bus_error_register <= 2'h0;
         fill_error_status_register <= 2'h0;
         read_data_error <= 1'b0;
      end else begin
         bus_error_register <= next_ber;
         fill_error_status_register <= next_fes;
         read_data_error <= next_rde;
      end
   end
   assign hard_error_irq = |bus_error_register;
   assign soft_error_irq = fill_error_status_register[`CER_FES_LOCK_BIT];

   chk_nxm_hard: assert property (@(posedge clock) disable iff (!rst_b)
      nxm_read |=> hard_error_irq && bus_error_register == 2'h3) else $error("no hard error on nxm");
   chk_nxm_soft: assert property (@(posedge clock) disable iff (!rst_b)
      nxm_read |=> ##1 soft_error_irq && fill_error_status_register == 2'h3) else $error("no soft error");

   // ****************************************
   // Speculative issue gating
   // ****************************************
   cer_req_if req ();
   assign req.valid = req_valid;
   assign req.kind = req_kind;
   assign req.speculative = req_speculative;
   assign req.executing = req_executing;
   assign req.data_ready = req_data_ready;
   assign req_issue = req.issue;
   cer_issue_gate u_gate (
      .req(req)
   );
   chk_io_wait: assert property (@(posedge clock) disable iff (!rst_b)
      (req_issue && req_kind == CER_REQ_IO) |-> req_executing && !req_speculative)
      else $error("speculative io issued");
   chk_write_wait: assert property (@(posedge clock) disable iff (!rst_b)
      (req_issue && req_kind == CER_REQ_MEM_WRITE) |-> req_data_ready && !req_speculative)
      else $error("write without data");

   // ****************************************
   // Wrong-path access violations
   // ****************************************
   logic next_acv_pending;
   logic next_acv_fault;
   logic next_drop;
   logic wrong_path_ok;
   always_comb begin
      wrong_path_ok = prefetch_wrong_path && branch_conditional;
      next_acv_pending = acv_pending;
      next_acv_fault = 1'b0;
      next_drop = 1'b0;
      if (mispredict && acv_pending) begin
         next_acv_pending = 1'b0;
         next_drop = 1'b1;
      end
      // New violation in the same cycle wins over the discard
      if (prefetch_acv && wrong_path_ok) begin
         next_acv_pending = 1'b1;
      end else if (prefetch_acv) begin
         next_acv_fault = 1'b1;
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         acv_pending <= 1'b0;
         acv_fault <= 1'b0;
         wrong_path_drop <= 1'b0;
      end else begin
         acv_pending <= next_acv_pending;
         acv_fault <= next_acv_fault;
         wrong_path_drop <= next_drop;
      end
   end
   chk_acv_drop: assert property (@(posedge clock) disable iff (!rst_b)
      (mispredict && acv_pending && !prefetch_acv) |=> wrong_path_drop && !acv_fault) else $error("acv not dropped");
   chk_wp_cond: assert property (@(posedge clock) disable iff (!rst_b)
      (prefetch_acv && prefetch_wrong_path && !branch_conditional) |=> acv_fault)
      else $error("unconditional wrong path accepted");

   // ****************************************
   // Cache enables and coherence
   // ****************************************
   logic next_icache_on;
   logic next_pcache_on;
   logic next_icache_flush;
   always_comb begin
      next_icache_on = icache_enable;
      next_pcache_on = pcache_enable;
      next_icache_flush = rei_exec;
   end
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         icache_on <= 1'b0;
         pcache_on <= 1'b0;
         icache_flush <= 1'b0;
      end else begin
         icache_on <= next_icache_on;
         pcache_on <= next_pcache_on;
         icache_flush <= next_icache_flush;
      end
   end
   // Primary cache snoops memory in every backup mode
   assign pcache_coherent = 1'b1;
   chk_rei_flush: assert property (@(posedge clock) disable iff (!rst_b)
      rei_exec |=> icache_flush) else $error("rei did not flush");
   chk_etm_coh: assert property (@(posedge clock) disable iff (!rst_b)
      (bcache_mode != `CER_BC_ON) |-> pcache_coherent) else $error("primary incoherent");

   // ****************************************
   // Translation buffer
   // ****************************************
   cer_tb_flush #(
      .ENTRIES(TB_ENTRIES)
   ) u_tb (
      .clock(clock),
      .rst_b(rst_b),
      .fill(tb_fill),
      .fill_index(tb_fill_index),
      .fill_process(tb_fill_process),
      .inval_all(tb_inval_all || tb_parity_error),
      .inval_single(tb_inval_single),
      .single_index(tb_single_index),
      .clear_process(load_process_context_instr_exec),
      .valid(tb_valid)
   );
endmodule

// file: cer_top_bench.sv
// Self-checking testbench for the cache error recovery control top
`timescale 1ns/1ps
`include "cer_map.svh"
module cer_top_bench;
   import cer_pkg::*;
   localparam int N = 8;
   localparam int ERR_LIMIT = 0;
   // ****************************************
   // Signals
   // ****************************************
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic nxm_read = 1'b0, ber_clear = 1'b0, fes_clear = 1'b0;
   logic req_valid = 1'b0, req_speculative = 1'b0, req_executing = 1'b0, req_data_ready = 1'b0;
   cer_req_kind_t req_kind = CER_REQ_MEM_READ;
   logic prefetch_wrong_path = 1'b0, branch_conditional = 1'b0, mispredict = 1'b0, prefetch_acv = 1'b0;
   logic icache_enable = 1'b0, pcache_enable = 1'b0, rei_exec = 1'b0, load_process_context_instr_exec = 1'b0;
   logic [1:0] bcache_mode = `CER_BC_OFF;
   logic tb_fill = 1'b0, tb_fill_process = 1'b0, tb_parity_error = 1'b0;
   logic tb_inval_all = 1'b0, tb_inval_single = 1'b0;
   logic [2:0] tb_fill_index = 3'h0, tb_single_index = 3'h0;
   logic [1:0] bus_error_register, fill_error_status_register;
   logic hard_error_irq, soft_error_irq, read_data_error, req_issue, acv_pending, acv_fault;
   logic wrong_path_drop, icache_on, pcache_on, pcache_coherent, icache_flush;
   logic [N-1:0] tb_valid;
   int err_count = 0;
   int cmp_count = 0;
   cer_top #(.TB_ENTRIES(N)) i_dut (.clock, .rst_b, .nxm_read, .ber_clear, .fes_clear, .bus_error_register,
      .fill_error_status_register, .hard_error_irq, .soft_error_irq, .read_data_error, .req_valid, .req_kind,
      .req_speculative, .req_executing, .req_data_ready, .req_issue, .prefetch_wrong_path, .branch_conditional,
      .mispredict, .prefetch_acv, .acv_pending, .acv_fault, .wrong_path_drop, .icache_enable, .pcache_enable,
      .bcache_mode, .icache_on, .pcache_on, .pcache_coherent, .rei_exec, .icache_flush, .tb_fill, .tb_fill_index,
      .tb_fill_process, .tb_parity_error, .tb_inval_all, .tb_inval_single, .tb_single_index, .load_process_context_instr_exec, .tb_valid);
   always #2.5 clock = ~clock;
   // ****************************************
   // Compare and closing tasks
   // ****************************************
   task automatic chk_bit(input logic got, input logic exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_nxm;
      @(posedge clock) nxm_read <= 1'b1;
      @(posedge clock) nxm_read <= 1'b0;
      #1;
      chk_vec({6'h00, bus_error_register}, 8'h03, "bus error bits");
      chk_bit(hard_error_irq, 1'b1, "hard irq");
      chk_bit(read_data_error, 1'b1, "read data error");
      chk_bit(soft_error_irq, 1'b0, "soft irq early");
      @(posedge clock) #1;
      chk_vec({6'h00, fill_error_status_register}, 8'h03, "fill status");
      chk_bit(soft_error_irq, 1'b1, "soft irq");
      chk_bit(read_data_error, 1'b0, "read data error pulse");
      chk_vec({6'h00, bus_error_register}, 8'h03, "bus error bits stand");
      @(posedge clock) begin
         ber_clear <= 1'b1;
         fes_clear <= 1'b1;
      end
      @(posedge clock) begin
         ber_clear <= 1'b0;
         fes_clear <= 1'b0;
      end
      #1;
      chk_vec({4'h0, bus_error_register, fill_error_status_register}, 8'h00, "cleared bits");
      chk_bit(hard_error_irq | soft_error_irq, 1'b0, "irqs cleared");
   endtask
   task automatic test_issue;
      logic exp;
      for (int k = 0; k < 3; k++) begin
         for (int m = 0; m < 8; m++) begin
            @(posedge clock) begin
               req_valid <= 1'b1;
               req_kind <= cer_req_kind_t'(k);
               req_speculative <= m[0];
               req_executing <= m[1];
               req_data_ready <= m[2];
            end
            #1;
            exp = (k == 0) | ((k == 1) & m[2] & !m[0]) | ((k == 2) & m[1] & !m[0]);
            chk_bit(req_issue, exp, "issue gate");
         end
      end
      @(posedge clock) req_valid <= 1'b0;
      #1 chk_bit(req_issue, 1'b0, "issue without valid");
   endtask
   task automatic test_acv;
      @(posedge clock) begin
         prefetch_acv <= 1'b1;
         prefetch_wrong_path <= 1'b1;
         branch_conditional <= 1'b1;
      end
      @(posedge clock) begin
         prefetch_acv <= 1'b0;
         mispredict <= 1'b1;
      end
      #1 chk_bit(acv_pending, 1'b1, "acv held pending");
      chk_bit(acv_fault, 1'b0, "no early fault");
      @(posedge clock) begin
         mispredict <= 1'b0;
         prefetch_wrong_path <= 1'b0;
         branch_conditional <= 1'b0;
      end
      #1 chk_vec({5'h00, wrong_path_drop, acv_pending, acv_fault}, 8'h04, "acv dropped");
      @(posedge clock) begin
         prefetch_acv <= 1'b1;
         prefetch_wrong_path <= 1'b1;
      end
      @(posedge clock) begin
         prefetch_acv <= 1'b0;
         prefetch_wrong_path <= 1'b0;
      end
      #1 chk_vec({5'h00, wrong_path_drop, acv_pending, acv_fault}, 8'h01, "unconditional wrong path faults");
      @(posedge clock) prefetch_acv <= 1'b1;
      @(posedge clock) prefetch_acv <= 1'b0;
      #1 chk_vec({5'h00, wrong_path_drop, acv_pending, acv_fault}, 8'h01, "acv delivered");
      @(posedge clock) #1 chk_bit(acv_fault, 1'b0, "fault pulse");
   endtask
   task automatic test_cache;
      @(posedge clock) begin
         icache_enable <= 1'b1;
         pcache_enable <= 1'b1;
         bcache_mode <= `CER_BC_ETM;
      end
      @(posedge clock) rei_exec <= 1'b1;
      #1 chk_vec({6'h00, icache_on, pcache_on}, 8'h03, "caches on");
      chk_bit(pcache_coherent, 1'b1, "coherent in transition mode");
      @(posedge clock) begin
         rei_exec <= 1'b0;
         bcache_mode <= `CER_BC_OFF;
         icache_enable <= 1'b0;
      end
      #1 chk_bit(icache_flush, 1'b1, "flush on return");
      @(posedge clock) #1 chk_bit(icache_flush, 1'b0, "flush pulse");
      chk_bit(icache_on, 1'b0, "icache off");
      chk_bit(pcache_coherent, 1'b1, "coherent with backup off");
   endtask
   task automatic test_recovery;
      int unit_errs;
      unit_errs = 0;
      @(posedge clock) begin
         icache_enable <= 1'b1;
         bcache_mode <= `CER_BC_ON;
      end
      @(posedge clock) icache_enable <= 1'b0;
      @(posedge clock) pcache_enable <= 1'b0;
      @(posedge clock) bcache_mode <= `CER_BC_ETM;
      #1 chk_vec({6'h00, icache_on, pcache_on}, 8'h00, "caches off for recovery");
      chk_vec({4'h0, bus_error_register, fill_error_status_register}, 8'h00, "status clear before flush");
      for (int blk = 0; blk < 2; blk++) begin
         @(posedge clock) #1 chk_vec({6'h00, fill_error_status_register}, 8'h00, "status after block");
         chk_bit(pcache_coherent, 1'b1, "coherent during flush");
         unit_errs += int'(hard_error_irq) + int'(soft_error_irq);
      end
      chk_bit(unit_errs > ERR_LIMIT, 1'b0, "error count over limit");
      @(posedge clock) bcache_mode <= `CER_BC_OFF;
      @(posedge clock) bcache_mode <= `CER_BC_ON;
      #1 chk_bit(pcache_on, 1'b0, "primary off at backup enable");
      @(posedge clock) rei_exec <= 1'b1;
      @(posedge clock) begin
         rei_exec <= 1'b0;
         pcache_enable <= 1'b1;
         icache_enable <= 1'b1;
      end
      #1 chk_bit(icache_flush, 1'b1, "instruction cache flushed");
      @(posedge clock) bcache_mode <= `CER_BC_OFF;
      #1 chk_vec({6'h00, icache_on, pcache_on}, 8'h03, "caches back on");
      chk_bit(pcache_coherent, 1'b1, "coherent after re-enable");
      @(posedge clock) icache_enable <= 1'b0;
      @(posedge clock) pcache_enable <= 1'b0;
      #1 chk_vec({6'h00, icache_on, pcache_on}, 8'h01, "instruction cache off first");
      @(posedge clock) #1 chk_vec({6'h00, icache_on, pcache_on}, 8'h00, "shutdown order");
   endtask
   task automatic test_tb;
      for (int i = 0; i < N; i++) begin
         @(posedge clock) begin
            tb_fill <= 1'b1;
            tb_fill_index <= 3'(i);
            tb_fill_process <= i[0];
         end
      end
      @(posedge clock) begin
         tb_fill <= 1'b0;
         load_process_context_instr_exec <= 1'b1;
      end
      #1 chk_vec(tb_valid, 8'hFF, "filled");
      @(posedge clock) begin
         load_process_context_instr_exec <= 1'b0;
         tb_inval_single <= 1'b1;
         tb_single_index <= 3'h2;
      end
      #1 chk_vec(tb_valid, 8'h55, "process entries cleared");
      @(posedge clock) begin
         tb_inval_single <= 1'b0;
         tb_parity_error <= 1'b1;
      end
      #1 chk_vec(tb_valid, 8'h51, "single invalidate");
      @(posedge clock) begin
         tb_parity_error <= 1'b0;
         tb_fill <= 1'b1;
         tb_fill_index <= 3'h7;
      end
      #1 chk_vec(tb_valid, 8'h00, "parity invalidates all");
      @(posedge clock) begin
         tb_fill <= 1'b0;
         tb_inval_all <= 1'b1;
      end
      #1 chk_vec(tb_valid, 8'h80, "refilled");
      @(posedge clock) tb_inval_all <= 1'b0;
      #1 chk_vec(tb_valid, 8'h00, "invalidate all");
   endtask
   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      #1 chk_vec({4'h0, bus_error_register, fill_error_status_register}, 8'h00, "reset error bits");
      chk_vec(tb_valid, 8'h00, "reset valid bits");
      test_nxm();
      test_issue();
      test_acv();
      test_cache();
      test_recovery();
      test_tb();
      stop_test();
   end
   initial begin
      repeat (2000) @(posedge clock);
      err_count++;
      stop_test();
   end
endmodule
